// file: hdl/postinc_load_store_decode.v
// Contract
// - access at base, then write base plus offset
// - custom forms only when custom parameter is 1
// - dest equals base: loaded data wins
// - immediate post-increment loads under opcode 0x0B
// - signed forms sign-extend, unsigned zero-extend
// - register post-increment loads, funct7 picks size
// - indexed loads, base plus rs2, no update
// - immediate post-increment stores, split immediate
// - register post-increment stores, offset in 11:7
// - indexed stores, base plus 11:7 register
// - event load only when cluster parameter is 1
// - event load word, base plus immediate
// - immediates are sign-extended
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "postinc_ls_defines.vh"
module postinc_load_store_decode #(
  parameter custom_ext_enable_param = 1,
  parameter cluster_ext_enable_param = 1
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_instr_valid,
  input wire [31:0] i_instr,
  input wire [31:0] i_rs1_data,
  input wire [31:0] i_rs2_data,
  input wire [31:0] i_rs3_data,
  output wire o_instr_ready,
  output wire o_illegal,
  output wire o_event_sleep,
  output wire [4:0] o_rs1_addr,
  output wire [4:0] o_rs2_addr,
  output wire [4:0] o_rs3_addr,
  output wire o_mem_req,
  output reg [31:0] o_mem_addr,
  output reg o_mem_we,
  output reg [3:0] o_mem_be,
  output reg [31:0] o_mem_wdata,
  input wire i_mem_gnt,
  input wire i_mem_rvalid,
  input wire [31:0] i_mem_rdata,
  output reg o_rf_we,
  output reg [4:0] o_rf_waddr,
  output reg [31:0] o_rf_wdata
);

  // field slices; register addresses go straight out to the register file
  wire [6:0] opc = i_instr[6:0];
  wire [2:0] f3 = i_instr[14:12];
  wire [6:0] f7 = i_instr[31:25];
  wire [4:0] rd = i_instr[11:7];
  wire [4:0] rs1 = i_instr[19:15];
  wire en_cust = (custom_ext_enable_param == 1);
  wire en_clus = (cluster_ext_enable_param == 1);
  wire [31:0] imm_i = {{20{i_instr[31]}}, i_instr[31:20]};
  wire [31:0] imm_s = {{20{i_instr[31]}}, i_instr[31:25], i_instr[11:7]};
  reg dec_ok;
  reg dec_ld;
  reg dec_pi;
  reg dec_uns;
  reg dec_ev;
  reg [1:0] dec_sz;
  reg [31:0] dec_off;

  // full encodings listed, so a stray funct7 bit never aliases a legal form
  always @* begin
    dec_ok = 1'b0;
    dec_ld = 1'b0;
    dec_pi = 1'b0;
    dec_uns = 1'b0;
    dec_ev = 1'b0;
    dec_sz = `SZ_W;
    dec_off = 32'h00000000;
    if (opc == `OPC_CUST0) begin
      case (f3)
        `F3_RR: begin
          dec_ok = en_clus;
          dec_ld = 1'b1;
          dec_ev = 1'b1;
          dec_off = imm_i;
        end
        `F3_B, `F3_H, `F3_W, `F3_BU, `F3_HU: begin
          dec_ok = en_cust;
          dec_ld = 1'b1;
          dec_pi = 1'b1;
          dec_uns = f3[2];
          dec_sz = f3[1:0];
          dec_off = imm_i;
        end
        default: begin
          dec_ok = 1'b0;
        end
      endcase
    end else if (opc == `OPC_CUST1) begin
      if (f3 == `F3_RR) begin
        case (f7)
          7'h00, 7'h08, 7'h01, 7'h09, 7'h02: begin
            dec_ok = en_cust;
            dec_ld = 1'b1;
            dec_pi = 1'b1;
            dec_uns = f7[3];
            dec_sz = f7[1:0];
            dec_off = i_rs2_data;
          end
          7'h04, 7'h0C, 7'h05, 7'h0D, 7'h06: begin
            dec_ok = en_cust;
            dec_ld = 1'b1;
            dec_uns = f7[3];
            dec_sz = f7[1:0];
            dec_off = i_rs2_data;
          end
          7'h10, 7'h11, 7'h12: begin
            dec_ok = en_cust;
            dec_pi = 1'b1;
            dec_sz = f7[1:0];
            dec_off = i_rs3_data;
          end
          7'h14, 7'h15, 7'h16: begin
            dec_ok = en_cust;
            dec_sz = f7[1:0];
            dec_off = i_rs3_data;
          end
          default: begin
            dec_ok = 1'b0;
          end
        endcase
      end else if (f3 == `F3_B || f3 == `F3_H || f3 == `F3_W) begin
        dec_ok = en_cust;
        dec_pi = 1'b1;
        dec_sz = f3[1:0];
        dec_off = imm_s;
      end
    end
  end

  assign o_rs1_addr = rs1;
  assign o_rs2_addr = i_instr[24:20];
  assign o_rs3_addr = i_instr[11:7];
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg ld_ff;
  reg uns_ff;
  reg pi_ff;
  reg ev_ff;
  reg [1:0] sz_ff;
  reg [1:0] lane_ff;
  reg [4:0] rd_ff;
  reg [4:0] base_ff;
  reg [31:0] inc_ff;
  reg wb_pend_ff;
  reg illegal_ff;
  reg req_done_ff;

  // busy while the second write-port cycle of a load is still owed
  wire idle = (state_ff == `ST_IDLE) && !wb_pend_ff;
  assign o_instr_ready = idle;
  assign o_mem_req = (state_ff == `ST_WAIT) && !req_done_ff;
  assign o_illegal = illegal_ff;
  assign o_event_sleep = (state_ff == `ST_WAIT) && ev_ff;
  wire take = idle && i_instr_valid;
  wire [31:0] acc_addr = dec_pi ? i_rs1_data : i_rs1_data + dec_off;
  wire [31:0] inc_addr = i_rs1_data + dec_off;
  wire [1:0] lo = acc_addr[1:0];

  reg [3:0] be;
  reg [31:0] wd;
  always @* begin
    case (dec_sz)
      `SZ_B: begin
        be = 4'h1 << lo;
        wd = {4{i_rs2_data[7:0]}};
      end
      `SZ_H: begin
        be = lo[1] ? 4'hC : 4'h3;
        wd = {2{i_rs2_data[15:0]}};
      end
      default: begin
        be = 4'hF;
        wd = i_rs2_data;
      end
    endcase
  end

  // lane shift first, so one extender serves every byte position
  wire [31:0] sh = i_mem_rdata >> {lane_ff, 3'h0};
  reg [31:0] ext;
  always @* begin
    case (sz_ff)
      `SZ_B: begin
        ext = {{24{sh[7] & !uns_ff}}, sh[7:0]};
      end
      `SZ_H: begin
        ext = {{16{sh[15] & !uns_ff}}, sh[15:0]};
      end
      default: begin
        ext = i_mem_rdata;
      end
    endcase
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `ST_IDLE: begin
        if (take && dec_ok) begin
          nxt_state = `ST_WAIT;
        end
      end
      `ST_WAIT: begin
        if (ld_ff ? i_mem_rvalid : (req_done_ff || i_mem_gnt)) begin
          nxt_state = `ST_IDLE;
        end
      end
      default: begin
        nxt_state = `ST_IDLE;
      end
    endcase
  end

  // stores finish at grant; loads wait for data, so base update trails the load
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= `ST_IDLE;
      ld_ff <= 1'b0;
      uns_ff <= 1'b0;
      pi_ff <= 1'b0;
      ev_ff <= 1'b0;
      sz_ff <= `SZ_W;
      lane_ff <= 2'h0;
      rd_ff <= 5'h00;
      base_ff <= 5'h00;
      inc_ff <= 32'h00000000;
      illegal_ff <= 1'b0;
      req_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      illegal_ff <= take && !dec_ok;
      if (take && dec_ok) begin
        ld_ff <= dec_ld;
        uns_ff <= dec_uns;
        pi_ff <= dec_pi;
        ev_ff <= dec_ev;
        sz_ff <= dec_sz;
        lane_ff <= lo;
        rd_ff <= rd;
        base_ff <= rs1;
        inc_ff <= inc_addr;
        req_done_ff <= 1'b0;
      end else if (o_mem_req && i_mem_gnt) begin
        req_done_ff <= 1'b1;
      end
    end
  end

  // request fields stand until the next legal instruction is taken
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_addr <= 32'h00000000;
      o_mem_we <= 1'b0;
      o_mem_be <= 4'h0;
      o_mem_wdata <= 32'h00000000;
    end else if (take && dec_ok) begin
      o_mem_addr <= {acc_addr[31:2], 2'h0};
      o_mem_we <= !dec_ld;
      o_mem_be <= dec_ld ? 4'hF : be;
      o_mem_wdata <= wd;
    end
  end

  // one write port: a post-increment load spends two cycles on it unless rd is the base register
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rf_we <= 1'b0;
      o_rf_waddr <= 5'h00;
      o_rf_wdata <= 32'h00000000;
      wb_pend_ff <= 1'b0;
    end else begin
      o_rf_we <= 1'b0;
      wb_pend_ff <= 1'b0;
      if (wb_pend_ff) begin
        o_rf_we <= 1'b1;
        o_rf_waddr <= base_ff;
        o_rf_wdata <= inc_ff;
      end else if (state_ff == `ST_WAIT && nxt_state == `ST_IDLE) begin
        if (ld_ff) begin
          o_rf_we <= 1'b1;
          o_rf_waddr <= rd_ff;
          o_rf_wdata <= ext;
          wb_pend_ff <= pi_ff && (base_ff != rd_ff);
        end else if (pi_ff) begin
          o_rf_we <= 1'b1;
          o_rf_waddr <= base_ff;
          o_rf_wdata <= inc_ff;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: hdl/postinc_ls_defines.vh
`ifndef POSTINC_LS_DEFINES_VH
`define POSTINC_LS_DEFINES_VH
`define OPC_CUST0 7'h0B
`define OPC_CUST1 7'h2B
`define F3_B 3'h0
`define F3_H 3'h1
`define F3_W 3'h2
`define F3_RR 3'h3
`define F3_BU 3'h4
`define F3_HU 3'h5
`define F7_LD_PI_BASE 5'h00
`define F7_LD_IDX_BASE 5'h02
`define F7_ST_PI 5'h08
`define F7_ST_IDX 5'h0A
`define SZ_B 2'h0
`define SZ_H 2'h1
`define SZ_W 2'h2
`define ST_IDLE 2'h0
`define ST_WAIT 2'h1
`endif

// file: dv/postinc_ls_chk.sv
`timescale 1ns/1ps
`default_nettype none
module postinc_ls_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_rs1_data,
  input wire logic o_instr_ready,
  input wire logic o_illegal,
  input wire logic o_event_sleep,
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_mem_we,
  input wire logic [3:0] o_mem_be,
  input wire logic i_mem_gnt,
  input wire logic i_mem_rvalid,
  input wire logic o_rf_we,
  input wire logic [4:0] o_rf_waddr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire tk = i_instr_valid && o_instr_ready;
  wire [6:0] opc = i_instr[6:0];
  wire [2:0] f3 = i_instr[14:12];
  wire [31:0] ba = i_rs1_data & 32'hFFFFFFFC;
  bad_op_a: assert property (tk && opc == 7'h0B && f3 > 3'h5
    |=> o_illegal && !o_mem_req) else $error("no illegal flag");
  st_at_base_a: assert property (tk && opc == 7'h2B && f3 < 3'h3
    |=> o_mem_req && o_mem_we && o_mem_addr == $past(ba)) else $error("store off base");
  ld_at_base_a: assert property (tk && opc == 7'h0B && f3[1:0] != 2'h3 && f3 < 3'h6
    |=> o_mem_req && !o_mem_we && o_mem_addr == $past(ba)) else $error("load off base");
  req_hold_a: assert property (o_mem_req && !i_mem_gnt
    |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)) else $error("request dropped");
  lane_be_a: assert property (o_mem_req && o_mem_we
    |-> o_mem_be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}) else $error("bad lanes");
  sleep_busy_a: assert property (o_event_sleep |-> !o_instr_ready) else $error("sleep while idle");
  ld_write_a: assert property (i_mem_rvalid |=> o_rf_we) else $error("load not written");
  rd_wins_a: assert property (o_rf_we && $past(o_rf_we)
    |-> o_rf_waddr != $past(o_rf_waddr)) else $error("same reg written twice");
  cv_sleep: cover property (o_event_sleep);
  cv_two_wr: cover property (o_rf_we ##1 o_rf_we);
  cv_store: cover property (o_mem_req && o_mem_we && i_mem_gnt);
endmodule
bind postinc_load_store_decode postinc_ls_chk u_postinc_ls_chk (.*);
`default_nettype wire

// file: dv/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [1:0] i_slow,
  output logic o_gnt = 1'b0,
  output logic o_rvalid = 1'b0,
  output logic [31:0] o_rdata = 32'h0
);
  logic [1:0] wait_ff = 2'h0;
  always @(posedge i_clk) begin
    o_gnt <= i_req && !o_gnt && wait_ff == i_slow;
    wait_ff <= (i_req && !o_gnt && wait_ff != i_slow) ? wait_ff + 2'h1 : 2'h0;
    o_rvalid <= o_gnt && i_req && !i_we;
    // idle bus toggles so stale data never passes for a reply
    o_rdata <= (o_gnt && i_req && !i_we) ? 32'h80F18283 : ~o_rdata;
  end
endmodule
`default_nettype wire

// file: dv/postinc_load_store_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module postinc_load_store_decode_tb_top;
  localparam logic [31:0] LE [5] = '{32'hFFFFFF83, 32'h83, 32'hFFFF8283, 32'h8283, 32'h80F18283};
  localparam logic [2:0] F3 [5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2};
  localparam logic [6:0] F7 [5] = '{7'h00, 7'h08, 7'h01, 7'h09, 7'h02};
  localparam logic [31:0] SM [3] = '{32'hFF, 32'hFFFF, 32'hFFFFFFFF};
  localparam logic [3:0] SB [3] = '{4'h1, 4'h3, 4'hF};
  logic i_clk = 0, i_rst_b = 0, i_instr_valid = 0, sl, il;
  logic [1:0] slow = 0;
  logic [31:0] i_instr = 0, ga, gw, rf [32];
  logic [3:0] gbe;
  logic [36:0] wq [$];
  integer failures = 0, n_tests = 0, m, s;
  wire o_instr_ready, o_illegal, o_event_sleep, o_mem_req, o_mem_we, o_rf_we, i_mem_gnt, i_mem_rvalid;
  wire [4:0] o_rs1_addr, o_rs2_addr, o_rs3_addr, o_rf_waddr;
  wire [3:0] o_mem_be;
  wire [31:0] o_mem_addr, o_mem_wdata, o_rf_wdata, i_mem_rdata;
  wire [31:0] i_rs1_data = rf[o_rs1_addr], i_rs2_data = rf[o_rs2_addr], i_rs3_data = rf[o_rs3_addr];
  postinc_load_store_decode u_postinc_load_store_decode (.*);
  mem_partner u_mem_partner (.i_clk, .i_req(o_mem_req), .i_we(o_mem_we), .i_slow(slow),
    .o_gnt(i_mem_gnt), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));
  initial forever #12.5 i_clk = ~i_clk;
  initial begin
    #100000 failures++;
    end_sim;
  end
  always @(negedge i_clk) begin
    if (o_rf_we === 1'b1) wq.push_back({o_rf_waddr, o_rf_wdata});
    if (o_mem_req && i_mem_gnt) {ga, gbe, gw} = {o_mem_addr, o_mem_be, o_mem_wdata};
    sl |= o_event_sleep;
    il |= o_illegal;
  end
  task chk(input string nm, input logic [36:0] g, e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task go(input logic [31:0] ins);
    integer k;
    wq = {};
    {ga, sl, il} = 0;
    @(posedge i_clk);
    i_instr_valid <= 1;
    i_instr <= ins;
    @(posedge i_clk);
    i_instr_valid <= 0;
    // bounded: ready must come back once the writes are done
    for (k = 0; k < 40 && !(k > 4 && o_instr_ready); k++) @(posedge i_clk);
    repeat (3) @(posedge i_clk);
  endtask
  task loads;
    for (m = 0; m < 3; m++) for (s = 0; s < 5; s++) begin
      slow <= s[1:0];
      go(m == 0 ? {12'hFFC, 5'h5, F3[s], 5'h6, 7'h0B}
        : {F7[s] | (m == 2 ? 7'h04 : 7'h00), 5'h7, 5'h5, 3'h3, 5'h6, 7'h2B});
      chk("ld addr", ga, m == 2 ? 32'h120 : 32'h100);
      chk("ld data", wq[0], {5'h6, LE[s]});
      chk("ld last", wq[wq.size() - 1], m == 0 ? {5'h5, 32'hFC} : m == 1 ? {5'h5, 32'h120} : {5'h6, LE[s]});
    end
  endtask
  task rd_wins;
    go({12'h004, 5'h5, 3'h2, 5'h5, 7'h0B});
    chk("rd wins", wq[wq.size() - 1], {5'h5, 32'h80F18283});
  endtask
  task stores;
    for (m = 0; m < 3; m++) for (s = 0; s < 3; s++) begin
      go(m == 0 ? {7'h7F, 5'h8, 5'h5, s[2:0], 5'h18, 7'h2B}
        : {(m == 1 ? 7'h10 : 7'h14) | s[6:0], 5'h8, 5'h5, 3'h3, 5'h9, 7'h2B});
      chk("st addr", ga, m == 2 ? 32'h140 : 32'h100);
      chk("st lane", {gbe, gw & SM[s]}, {SB[s], 32'h11223344 & SM[s]});
      chk("st base", wq.size() ? wq[0] : 37'h0, m == 0 ? {5'h5, 32'hF8} : m == 1 ? {5'h5, 32'h140} : 37'h0);
    end
  endtask
  task ev_load;
    slow <= 2'h3;
    go({12'hFF0, 5'h5, 3'h3, 5'h6, 7'h0B});
    chk("ev addr", ga, 32'hF0);
    chk("ev write", {wq.size() == 1, wq[0]}, {1'b1, 5'h6, 32'h80F18283});
    chk("ev sleep", sl, 1);
  endtask
  task bad_op;
    go({12'h0, 5'h5, 3'h6, 5'h6, 7'h0B});
    chk("illegal", {il, ga}, {1'b1, 32'h0});
  endtask
  task end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    for (m = 0; m < 32; m++) rf[m] = 0;
    rf[5] = 32'h100;
    rf[7] = 32'h20;
    rf[8] = 32'h11223344;
    rf[9] = 32'h40;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1;
    loads;
    rd_wins;
    stores;
    ev_load;
    bad_op;
    end_sim;
  end
endmodule
`default_nettype wire
